// file: common/cbbr_pkg.sv
package cbbr_pkg;
  // register word indices; byte address is index times WORD_BYTES
  localparam int WORD_BYTES = 4;
  localparam logic [5:0] IDX_STATUS = 6'h16;
  localparam logic [5:0] IDX_PRIMARY = 6'h18;
  localparam logic [5:0] IDX_SECONDARY = 6'h19;
  localparam logic [5:0] IDX_HIGHEST = 6'h1a;
  localparam logic [5:0] IDX_INT_STATUS = 6'h30;
  localparam logic [5:0] IDX_INT_CLEAR = 6'h31;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h32;
  localparam logic [5:0] IDX_BRIDGE_CTRL = 6'h3e;
  // downstream error status layout
  localparam int PARITY_FLAG_BIT = 8;
  localparam int TIMING_LSB = 9;
  localparam logic [1:0] TIMING_CODE = 2'h1;
  localparam int BACK_TO_BACK_BIT = 7;
  localparam int USER_FEATURE_BIT = 6;
  localparam int HIGH_SPEED_BIT = 5;
  localparam logic [15:0] STATUS_RESET = 16'h0200;
  // bridge control layout
  localparam int PARITY_RESP_BIT = 0;
  localparam logic [7:0] BUS_INDEX_RESET = 8'h00;
  typedef enum logic [1:0] {ROUTE_NONE, ROUTE_LOCAL, ROUTE_PASS} cbbr_route_t;
endpackage

// file: common/cbbr_route_if.sv
`timescale 1ns/1ps
interface cbbr_route_if
#(
  parameter int NF = 2,
  parameter int FB = 1
);
  logic [7:0] cfgBus;
  logic [7:0] primaryBus;
  logic [NF-1:0][7:0] secBus;
  logic [NF-1:0][7:0] subBus;
  cbbr_pkg::cbbr_route_t kind;
  logic [FB-1:0] socket;
  modport bridge
  (
    output cfgBus, primaryBus, secBus, subBus,
    input kind, socket
  );
  modport decoder
  (
    input cfgBus, primaryBus, secBus, subBus,
    output kind, socket
  );
endinterface

// file: hdl/cbbr_parity_flag.sv
`timescale 1ns/1ps
module cbbr_parity_flag
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic cardParityErrorLine, // card parity error asserted
  input wire logic masterOfData, // bridge masters this data phase
  input wire logic parityRespEnable, // parity error response bit
  input wire logic clearWrite, // software wrote 1 to the flag
  output logic downstreamParityFlag, // sticky flag
  output logic parityEvent // new detection this cycle
);
  wire logic setCond;
  assign setCond = cardParityErrorLine & masterOfData &
                   parityRespEnable;
  assign parityEvent = setCond & ~downstreamParityFlag;

  // a detection in the clearing cycle wins
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      downstreamParityFlag <= 1'b0;
    else
      downstreamParityFlag <= setCond |
                              (downstreamParityFlag & ~clearWrite);
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_flag_sets: assert property (setCond |=> downstreamParityFlag)
    else $error("parity flag not set");
  a_flag_cause: assert property (
    $rose(downstreamParityFlag) |-> $past(setCond))
    else $error("parity flag set without cause");
  a_flag_clears: assert property (
    clearWrite && !setCond |=> !downstreamParityFlag)
    else $error("parity flag not cleared");
  a_flag_holds: assert property (
    downstreamParityFlag && !clearWrite |=> downstreamParityFlag)
    else $error("parity flag lost");
endmodule

// file: hdl/cbbr_bus_route.sv
`timescale 1ns/1ps
module cbbr_bus_route
  import cbbr_pkg::*;
#(
  parameter int NF = 2,
  parameter int FB = 1
)
(
  cbbr_route_if.decoder rif // bus numbers in, decision out
);
  logic [NF-1:0] isLocal;
  logic [NF-1:0] isPass;

  genvar g;
  generate
    for (g = 0; g < NF; g++)
    begin : gSock
      assign isLocal[g] = rif.cfgBus == rif.secBus[g];
      assign isPass[g] = rif.cfgBus > rif.secBus[g] &&
                         rif.cfgBus <= rif.subBus[g];
    end
  endgenerate

  // lowest socket wins; a cycle for the primary bus stays there
  always_comb
  begin
    rif.kind = ROUTE_NONE;
    rif.socket = '0;
    for (int f = NF - 1; f >= 0; f--)
    begin
      if (isLocal[f] || isPass[f])
      begin
        rif.kind = isLocal[f] ? ROUTE_LOCAL : ROUTE_PASS;
        rif.socket = FB'(f);
      end
    end
    if (rif.cfgBus == rif.primaryBus)
      rif.kind = ROUTE_NONE;
  end
endmodule

// file: hdl/cbbr_top.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
// How it works
// - a card parity error while mastering with response on sets the flag.
// - writing 1 clears the parity flag, 0 leaves it, and it reads 0 unset.
// - the back-to-back capability bit of the status reads as constant 0.
// - the user feature support bit of the status reads as constant 0.
// - the high speed capability bit of the status reads as constant 0.
// - status bits 4 to 0 read as zero and ignore writes.
// - the primary bus index is 8-bit read/write at index 18h, reset 00h.
// - each socket has its own 8-bit secondary bus index at 19h, reset 00h.
// - each socket has its own 8-bit highest index at 1Ah, reset 00h.
// - forwarding is decided from all three bus indices together.
// - status bits 10 to 9 read as the constant select timing code 01b.
module cbbr_top
  import cbbr_pkg::*;
#(
  parameter int FUNC_BITS = 1,
  parameter int ADDR_W = 12
)
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [2**FUNC_BITS-1:0] cardParityErrorLine, // per socket
  input wire logic [2**FUNC_BITS-1:0] masterOfData, // per socket
  input wire logic cfgValid, // config cycle present
  input wire logic [7:0] cfgBus, // config cycle bus number
  output logic routeValid, // decision pulse
  output logic routeLocal, // issue as local cycle
  output logic routePass, // pass on unchanged
  output logic [FUNC_BITS-1:0] routeSocket, // socket chosen
  output logic interruptReq // level interrupt
);
  localparam int NF = 2**FUNC_BITS;

  function automatic logic cbbrHit(input logic [ADDR_W-1:0] a,
                                   input logic [5:0] i);
    // word index times WORD_BYTES, upper bits clear
    return a[7:0] == {i, 2'b00} && a[ADDR_W-1:8+FUNC_BITS] == '0;
  endfunction

  wire logic setupPhase;
  wire logic accessDone;
  wire logic wrDone;
  wire logic [FUNC_BITS-1:0] fnSel;
  wire logic fnZero;
  wire logic hitStatus;
  wire logic hitPrimary;
  wire logic hitSecondary;
  wire logic hitHighest;
  wire logic hitCtrl;
  wire logic hitIntStatus;
  wire logic hitIntClear;
  wire logic hitIntEnable;
  wire logic mapped;
  logic [31:0] readWord;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wrDone = accessDone & pwrite;
  assign fnSel = paddr[8 +: FUNC_BITS];
  assign fnZero = fnSel == '0;
  assign hitStatus = cbbrHit(paddr, IDX_STATUS);
  assign hitPrimary = cbbrHit(paddr, IDX_PRIMARY);
  assign hitSecondary = cbbrHit(paddr, IDX_SECONDARY);
  assign hitHighest = cbbrHit(paddr, IDX_HIGHEST);
  assign hitCtrl = cbbrHit(paddr, IDX_BRIDGE_CTRL);
  assign hitIntStatus = cbbrHit(paddr, IDX_INT_STATUS) & fnZero;
  assign hitIntClear = cbbrHit(paddr, IDX_INT_CLEAR) & fnZero;
  assign hitIntEnable = cbbrHit(paddr, IDX_INT_ENABLE) & fnZero;
  assign mapped = hitStatus | hitPrimary | hitSecondary | hitHighest |
                  hitCtrl | hitIntStatus | hitIntClear | hitIntEnable;

  // registers
  logic [7:0] primaryBusIndex;
  logic [NF-1:0][7:0] secondaryBusIndex;
  logic [NF-1:0][7:0] highestDownstreamBusIndex;
  logic [NF-1:0] parityRespEnable;
  logic [NF-1:0] downstreamParityFlag;
  logic [NF-1:0] parityEvent;
  logic [NF-1:0][15:0] downstreamErrorStatus;
  logic [NF-1:0] intStatus;
  logic [NF-1:0] intEnable;
  logic [NF-1:0] intClear;
  logic [NF-1:0] next_intStatus;
  logic [NF-1:0] next_intEnable;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      primaryBusIndex <= BUS_INDEX_RESET;
    else if (wrDone && hitPrimary)
      primaryBusIndex <= pwdata[7:0];
  end

  genvar g;
  generate
    for (g = 0; g < NF; g++)
    begin : gFunc
      wire logic fnHere;
      assign fnHere = fnSel == FUNC_BITS'(g);

      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          secondaryBusIndex[g] <= BUS_INDEX_RESET;
          highestDownstreamBusIndex[g] <= BUS_INDEX_RESET;
          parityRespEnable[g] <= 1'b0;
        end
        else if (wrDone && fnHere)
        begin
          if (hitSecondary)
            secondaryBusIndex[g] <= pwdata[7:0];
          if (hitHighest)
            highestDownstreamBusIndex[g] <= pwdata[7:0];
          if (hitCtrl)
            parityRespEnable[g] <= pwdata[PARITY_RESP_BIT];
        end
      end

      cbbr_parity_flag uFlag
      (
        .clock(clock),
        .sys_rst(sys_rst),
        .cardParityErrorLine(cardParityErrorLine[g]),
        .masterOfData(masterOfData[g]),
        .parityRespEnable(parityRespEnable[g]),
        .clearWrite(wrDone & fnHere & hitStatus &
                    pwdata[PARITY_FLAG_BIT]),
        .downstreamParityFlag(downstreamParityFlag[g]),
        .parityEvent(parityEvent[g])
      );

      // writes to the constant bits have no target
      always_comb
      begin
        downstreamErrorStatus[g] = '0;
        downstreamErrorStatus[g][TIMING_LSB +: 2] = TIMING_CODE;
        downstreamErrorStatus[g][PARITY_FLAG_BIT] = downstreamParityFlag[g];
        downstreamErrorStatus[g][BACK_TO_BACK_BIT] = 1'b0;
        downstreamErrorStatus[g][USER_FEATURE_BIT] = 1'b0;
        downstreamErrorStatus[g][HIGH_SPEED_BIT] = 1'b0;
      end
    end
  endgenerate

  // interrupt: new detection wins over a clear in the same cycle
  assign intClear = (wrDone && hitIntClear) ? pwdata[NF-1:0] : '0;
  assign next_intStatus = parityEvent | (intStatus & ~intClear);
  assign next_intEnable = (wrDone && hitIntEnable) ? pwdata[NF-1:0]
                                                   : intEnable;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      intStatus <= '0;
      intEnable <= '0;
      interruptReq <= 1'b0;
    end
    else
    begin
      intStatus <= next_intStatus;
      intEnable <= next_intEnable;
      interruptReq <= |(next_intStatus & next_intEnable);
    end
  end

  // read data are captured in the setup cycle for a zero-wait answer
  assign readWord =
    hitStatus ? {16'h0000, downstreamErrorStatus[fnSel]} :
    hitPrimary ? {24'h000000, primaryBusIndex} :
    hitSecondary ? {24'h000000, secondaryBusIndex[fnSel]} :
    hitHighest ? {24'h000000, highestDownstreamBusIndex[fnSel]} :
    hitCtrl ? {31'h00000000, parityRespEnable[fnSel]} :
    hitIntStatus ? {{(32-NF){1'b0}}, intStatus} :
    hitIntEnable ? {{(32-NF){1'b0}}, intEnable} :
    32'h00000000;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= (setupPhase && !pwrite) ? readWord : 32'h00000000;
      pready <= setupPhase;
      pslverr <= setupPhase & ~mapped;
    end
  end

  // configuration cycle routing
  cbbr_route_if #(.NF(NF), .FB(FUNC_BITS)) rif();
  assign rif.cfgBus = cfgBus;
  assign rif.primaryBus = primaryBusIndex;
  assign rif.secBus = secondaryBusIndex;
  assign rif.subBus = highestDownstreamBusIndex;

  cbbr_bus_route #(.NF(NF), .FB(FUNC_BITS)) uRoute
  (
    .rif(rif)
  );

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      routeValid <= 1'b0;
      routeLocal <= 1'b0;
      routePass <= 1'b0;
      routeSocket <= '0;
    end
    else
    begin
      routeValid <= cfgValid;
      routeLocal <= cfgValid && rif.kind == ROUTE_LOCAL;
      routePass <= cfgValid && rif.kind == ROUTE_PASS;
      routeSocket <= cfgValid ? rif.socket : '0;
    end
  end

  // status read in its access cycle, and a read setup cycle
  wire logic statusRead;
  wire logic readSetup;
  assign statusRead = accessDone & ~pwrite & hitStatus;
  assign readSetup = setupPhase & ~pwrite;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_ready_timing: assert property (
    setupPhase |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
  a_slverr_unmapped: assert property (
    setupPhase && !mapped |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_read_idle: assert property (
    !$past(readSetup) |-> prdata == 32'h00000000)
    else $error("read data outside access cycle");
  a_status_timing: assert property (
    statusRead |-> prdata[10:9] == 2'b01)
    else $error("select timing code wrong");
  a_status_b2b: assert property (
    statusRead |-> !prdata[7])
    else $error("back to back bit set");
  a_status_feature: assert property (
    statusRead |-> !prdata[6])
    else $error("user feature bit set");
  a_status_speed: assert property (
    statusRead |-> !prdata[5])
    else $error("high speed bit set");
  a_status_reserved: assert property (
    statusRead |-> prdata[4:0] == 5'h00 && prdata[31:11] == '0)
    else $error("reserved status bits set");
  a_primary_write: assert property (
    wrDone && hitPrimary |=> primaryBusIndex == $past(pwdata[7:0]))
    else $error("primary index not written");
  a_secondary_write: assert property (
    wrDone && hitSecondary |=>
      secondaryBusIndex[$past(fnSel)] == $past(pwdata[7:0]))
    else $error("secondary index not written");
  a_highest_write: assert property (
    wrDone && hitHighest |=>
      highestDownstreamBusIndex[$past(fnSel)] == $past(pwdata[7:0]))
    else $error("highest index not written");
  a_ctrl_write: assert property (
    wrDone && hitCtrl |=>
      parityRespEnable[$past(fnSel)] == $past(pwdata[PARITY_RESP_BIT]))
    else $error("parity response enable not written");
  a_route_local: assert property (
    cfgValid && cfgBus == secondaryBusIndex[0] &&
      cfgBus != primaryBusIndex |=>
      routeValid && routeLocal && routeSocket == '0)
    else $error("local cycle not routed");
  a_route_primary: assert property (
    cfgValid && cfgBus == primaryBusIndex |=>
      routeValid && !routeLocal && !routePass)
    else $error("primary cycle forwarded");
  a_route_pass: assert property (
    cfgValid && cfgBus > secondaryBusIndex[0] &&
      cfgBus <= highestDownstreamBusIndex[0] &&
      cfgBus != primaryBusIndex |=> routePass)
    else $error("cycle not passed on");
  a_route_valid: assert property (
    cfgValid |=> routeValid && !(routeLocal && routePass))
    else $error("route decision missing");
  a_route_idle: assert property (
    !cfgValid |=> !routeValid && !routeLocal && !routePass)
    else $error("route decision without cycle");
  a_irq_level: assert property (
    interruptReq == |(intStatus & intEnable))
    else $error("interrupt level wrong");
  a_int_enable_write: assert property (
    wrDone && hitIntEnable |=> intEnable == $past(pwdata[NF-1:0]))
    else $error("interrupt enable not written");
  a_int_event: assert property (
    |parityEvent |=> (intStatus & $past(parityEvent)) == $past(parityEvent))
    else $error("parity event not latched");
  a_parity_read: assert property (
    statusRead && !$past(downstreamParityFlag[fnSel]) |-> !prdata[8])
    else $error("parity flag reads set");
  a_parity_mirror: assert property (
    statusRead |-> prdata[8] == $past(downstreamParityFlag[fnSel]))
    else $error("parity flag read wrong");

  c_status_read: cover property (statusRead && prdata[8]);
  c_route_pass: cover property (routeValid && routePass);
  c_far_local: cover property (routeValid && routeLocal && routeSocket != '0);
  c_irq_raised: cover property (interruptReq);
  c_irq_cleared: cover property (wrDone && hitIntClear && interruptReq);
endmodule

// file: verification/cbbr_card_model.sv
`timescale 1ns/1ps
module cbbr_card_model
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic fire, // start one error report
  input wire logic sock, // socket that reports
  input wire logic [3:0] lag, // cycles before the report
  output logic [1:0] cardParityErrorLine // error line per socket
);
  logic busy;
  logic who;
  logic [3:0] waitCnt;
  // a card flags a data parity error lag+1 cycles after the edge that samples fire, for one cycle
  always @(posedge clock or posedge sys_rst)
  begin
    cardParityErrorLine <= 2'h0;
    if (sys_rst)
    begin
      busy <= 1'b0;
      waitCnt <= 4'h0;
      who <= 1'b0;
    end
    else if (fire)
    begin
      busy <= 1'b1;
      waitCnt <= lag;
      who <= sock;
    end
    else if (busy && waitCnt == 4'h0)
    begin
      busy <= 1'b0;
      cardParityErrorLine[who] <= 1'b1;
    end
    else if (busy)
      waitCnt <= waitCnt - 4'h1;
  end
endmodule

// file: verification/cardbus_bridge_bus_number_status_test.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("wrong value at %0t: %h, expected %h", $time, (a), (b)); \
    end \
  end
module cardbus_bridge_bus_number_status_test;
  import cbbr_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] masterOfData = 2'h0;
  logic cfgValid = 1'b0;
  logic [7:0] cfgBus = 8'h00;
  logic fire = 1'b0;
  logic sock = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [31:0] prdata, rdq;
  logic [1:0] cardParityErrorLine;
  logic pready, pslverr, errq, routeValid, routeLocal, routePass;
  logic routeSocket, interruptReq;
  logic [2:0] ex;
  logic [2:0] exq[$];
  int nb;
  int fails = 0;
  int checks = 0;
  int seed = 32'hecbe;
  int prim;
  int sec[2];
  int hi[2];
  int bl[9] = '{3, 7, 8, 9, 12, 13, 19, 20, 21};

  always #20 clock = ~clock;

  cbbr_top uut
  (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .cardParityErrorLine(cardParityErrorLine),
    .masterOfData(masterOfData), .cfgValid(cfgValid), .cfgBus(cfgBus),
    .routeValid(routeValid), .routeLocal(routeLocal),
    .routePass(routePass), .routeSocket(routeSocket),
    .interruptReq(interruptReq)
  );
  cbbr_card_model card
  (
    .clock(clock), .sys_rst(sys_rst), .fire(fire), .sock(sock),
    .lag(lag), .cardParityErrorLine(cardParityErrorLine)
  );

  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16)
    begin
      fails++;
      stop_test;
    end
  endtask

  function automatic logic [11:0] ad(input logic [5:0] i, input int f);
    return {3'h0, f[0], i, 2'h0};
  endfunction

  // expected decision: {socket, pass, local}, lowest socket first
  function automatic logic [2:0] route(input int bus);
    if (bus == prim)
      return 3'h0;
    for (int s = 0; s < 2; s++)
    begin
      if (bus == sec[s])
        return {s[0], 2'h1};
      if (bus > sec[s] && bus <= hi[s])
        return {s[0], 2'h2};
    end
    return 3'h0;
  endfunction

  task setbus;
    bus(1'b1, ad(IDX_PRIMARY, 0), 32'(prim));
    for (int f = 0; f < 2; f++)
    begin
      bus(1'b1, ad(IDX_SECONDARY, f), 32'(sec[f]));
      bus(1'b1, ad(IDX_HIGHEST, f), 32'(hi[f]));
    end
  endtask

  task err(input int f, input logic [3:0] l);
    @(posedge clock);
    fire <= 1'b1;
    sock <= f[0];
    lag <= l;
    @(posedge clock);
    fire <= 1'b0;
    repeat (l + 5) @(posedge clock);
  endtask

  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    for (int f = 0; f < 2; f++)
    begin
      bus(1'b0, ad(IDX_STATUS, f), 0);
      `CHK(rdq[15:0], 16'h0200)
      bus(1'b0, ad(IDX_PRIMARY, f), 0);
      `CHK(rdq[7:0], 8'h00)
      bus(1'b0, ad(IDX_SECONDARY, f), 0);
      `CHK(rdq[7:0], 8'h00)
      bus(1'b0, ad(IDX_HIGHEST, f), 0);
      `CHK(rdq[7:0], 8'h00)
    end
    bus(1'b1, ad(IDX_STATUS, 0), 32'hffffffff);
    bus(1'b0, ad(IDX_STATUS, 0), 0);
    `CHK(rdq[15:0], 16'h0200)
    bus(1'b0, ad(IDX_INT_STATUS, 1), 0);
    `CHK(errq, 1'b1)
    prim = $random(seed) & 255;
    for (int f = 0; f < 2; f++)
    begin
      sec[f] = $random(seed) & 255;
      hi[f] = $random(seed) & 255;
    end
    setbus;
    for (int f = 0; f < 2; f++)
    begin
      bus(1'b0, ad(IDX_PRIMARY, f), 0);
      `CHK(rdq[7:0], prim[7:0])
      bus(1'b0, ad(IDX_SECONDARY, f), 0);
      `CHK(rdq[7:0], sec[f][7:0])
      bus(1'b0, ad(IDX_HIGHEST, f), 0);
      `CHK(rdq[7:0], hi[f][7:0])
    end
    for (int f = 0; f < 2; f++)
    begin
      // master only, response only, then both
      for (int c = 0; c < 3; c++)
      begin
        bus(1'b1, ad(IDX_BRIDGE_CTRL, f), 32'(c != 0));
        masterOfData[f] <= c != 1;
        err(f, 4'(c * 3));
        bus(1'b0, ad(IDX_STATUS, f), 0);
        `CHK(rdq[15:0], {7'h01, c == 2, 8'h00})
      end
      bus(1'b0, ad(IDX_INT_STATUS, 0), 0);
      `CHK(rdq[1:0], 2'(1 << f))
      `CHK(interruptReq, 1'b0)
      bus(1'b1, ad(IDX_INT_ENABLE, 0), 32'h3);
      settle;
      `CHK(interruptReq, 1'b1)
      bus(1'b1, ad(IDX_STATUS, f), 32'h0);
      bus(1'b0, ad(IDX_STATUS, f), 0);
      `CHK(rdq[8], 1'b1)
      bus(1'b1, ad(IDX_STATUS, f), 32'h100);
      bus(1'b0, ad(IDX_STATUS, f), 0);
      `CHK(rdq[15:0], 16'h0200)
      bus(1'b1, ad(IDX_INT_CLEAR, 0), 32'(1 << f));
      bus(1'b1, ad(IDX_INT_ENABLE, 0), 32'h0);
      settle;
      `CHK(interruptReq, 1'b0)
      masterOfData[f] <= 1'b0;
    end
    prim = 3;
    sec = '{8, 20};
    hi = '{12, 20};
    setbus;
    // back-to-back cycles; each answer is seen two edges after its drive
    for (int i = 0; i < 18; i++)
    begin
      @(posedge clock);
      if (i >= 2)
      begin
        ex = exq.pop_front();
        `CHK(routeValid, 1'b1)
        `CHK({routeSocket, routePass, routeLocal}, ex)
      end
      if (i < 16)
      begin
        nb = (i < 9) ? bl[i] : $random(seed) & 31;
        cfgValid <= 1'b1;
        cfgBus <= 8'(nb);
        exq.push_back(route(nb));
      end
      else
      begin
        cfgValid <= 1'b0;
        cfgBus <= ~cfgBus;
      end
    end
    settle;
    `CHK(routeValid, 1'b0)
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, ad(IDX_SECONDARY, 1), 0);
    `CHK(rdq[7:0], 8'h00)
    stop_test;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    stop_test;
  end
endmodule
